// ---- include/status_word_pkg.sv ----
package status_word_pkg;
  // Bit positions in the combined status word
  localparam int NEG_BIT = 31;
  localparam int ZERO_BIT = 30;
  localparam int CARRY_BIT = 29;
  localparam int OVF_BIT = 28;
  localparam int SAT_BIT = 27;
  localparam int EXEC_HI_MSB = 26;
  localparam int EXEC_HI_LSB = 25;
  localparam int COMPACT_BIT = 24;
  localparam int EXEC_LO_MSB = 15;
  localparam int EXEC_LO_LSB = 10;
  localparam int RESUME_MSB = 15;
  localparam int RESUME_LSB = 12;
  localparam int EXC_NUM_MSB = 8;
  localparam int EXC_NUM_W = 9;

  // Part select masks for special-register moves
  localparam logic [2:0] SEL_APP = 3'h1;
  localparam logic [2:0] SEL_INT = 3'h2;
  localparam logic [2:0] SEL_EXEC = 3'h4;

  // Exception numbers
  localparam logic [8:0] EXC_THREAD = 9'h000;
  localparam logic [8:0] EXC_NMI = 9'h002;
  localparam logic [8:0] EXC_HARD = 9'h003;
  localparam logic [8:0] EXC_MEM = 9'h004;
  localparam logic [8:0] EXC_BUS = 9'h005;
  localparam logic [8:0] EXC_USAGE = 9'h006;
  localparam logic [8:0] EXC_SVC = 9'h00b;
  localparam logic [8:0] EXC_PEND_SERVICE = 9'h00e;
  localparam logic [8:0] EXC_TICK = 9'h00f;
  localparam logic [8:0] EXC_IRQ_BASE = 9'h010;
  localparam logic [8:0] EXC_IRQ_LAST = 9'h053;

  // Reset values
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [8:0] EXC_NUM_RST = 9'h000;
  localparam logic [7:0] EXEC_STATE_RST = 8'h00;
  localparam logic XFER_HELD_RST = 1'b0;
  localparam logic EXC_LEGAL_RST = 1'b1;
  localparam logic [31:0] READ_DATA_RST = 32'h0000_0000;
  localparam logic [31:0] STACK_WORD_RST = 32'h0100_0000;

  // Conditional-block tracker states
  typedef enum logic [1:0]
  {
    BLK_IDLE = 2'b00,
    BLK_COND = 2'b01,
    BLK_HELD = 2'b11
  } block_state_e;
endpackage : status_word_pkg

// ---- rtl/cond_block_tracker.sv ----
`timescale 1ns/1ns
// Tracks the conditional-block state across up to four instructions
module cond_block_tracker
  import status_word_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset
  input wire logic block_start, // Block instruction retires
  input wire logic [7:0] block_init, // Condition and mask byte
  input wire logic instr_retire, // Instruction in block retires
  input wire logic clear, // Abandon the block
  output logic [7:0] block_state, // Condition/mask byte for next cycle
  output logic block_active // Block in progress next cycle
);
  block_state_e st_q, st_d;
  logic [7:0] bits_q, bits_d;

  // Next state: the mask shifts once per retired instruction
  always_comb
  begin
    st_d = st_q;
    bits_d = bits_q;
    case (st_q)
      BLK_IDLE:
      begin
        if (block_start)
        begin
          bits_d = block_init;
          st_d = BLK_COND;
        end
      end
      BLK_COND, BLK_HELD:
      begin
        if (clear)
        begin
          bits_d = 8'h00;
          st_d = BLK_IDLE;
        end
        else if (instr_retire)
        begin
          // Low mask bit of condition: same or inverse per slot
          if (bits_q[2:0] == 3'h0)
          begin
            bits_d = 8'h00;
            st_d = BLK_IDLE;
          end
          else
          begin
            bits_d = {bits_q[7:5], bits_q[4:0] << 1};
            st_d = BLK_HELD;
          end
        end
      end
      default:
      begin
        st_d = BLK_IDLE;
        bits_d = 8'h00;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= BLK_IDLE;
      bits_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      bits_q <= bits_d;
    end
  end

  // Next values go out so the owner's register tracks without a lag
  assign block_state = bits_d;
  assign block_active = (st_d != BLK_IDLE);
endmodule : cond_block_tracker

// ---- rtl/program_status_register.sv ----
`timescale 1ns/1ns
module program_status_register
  import status_word_pkg::*;
#(
  parameter int IRQ_COUNT = 68 // External interrupt lines
)
(
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset, active high
  input wire logic flags_we, // Flag-setting instruction retires
  input wire logic flag_n, // Result negative or less-than
  input wire logic flag_z, // Result zero
  input wire logic flag_c, // Carry or no-borrow
  input wire logic flag_v, // Overflow
  input wire logic sat_event, // Saturate instruction saturated
  input wire logic sr_read, // Special-register read
  input wire logic sr_write, // Special-register write
  input wire logic [2:0] sr_sel, // Part select mask
  input wire logic [31:0] sr_wdata, // Write data
  input wire logic exc_enter, // Exception entry
  input wire logic exc_return, // Exception return
  input wire logic [8:0] exc_number, // Number of entered exception
  input wire logic [8:0] exc_ret_number, // Number restored on return
  input wire logic [7:0] exc_ret_exec, // Execution state restored on return
  input wire logic xfer_suspend, // Multi-register transfer interrupted
  input wire logic [3:0] xfer_next_reg, // Next register to transfer
  input wire logic xfer_resume_done, // Resumed transfer has taken state
  input wire logic block_start, // Conditional-block instruction retires
  input wire logic [7:0] block_init, // Block condition and mask
  input wire logic block_retire, // Instruction inside block retires
  output logic [31:0] sr_rdata, // Read data
  output logic [31:0] stacked_word, // Full word for stacking
  output logic [3:0] resume_reg, // Register at which to resume
  output logic resume_valid, // Transfer state is held
  output logic [7:0] cond_state, // Live execution state byte, block or transfer
  output logic exc_valid_num // Active number is a legal encoding
);
  logic [4:0] flags_q, flags_d;
  logic [8:0] exc_q, exc_d;
  logic [7:0] exec_q, exec_d;
  logic xfer_q, xfer_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] stack_q, stack_d;
  logic legal_q, legal_d;
  logic [7:0] blk_bits;
  logic blk_active;
  logic [31:0] full_word;

  // Legal exception encodings
  function automatic logic exc_legal(input logic [8:0] num);
    logic ok;
    ok = 1'b0;
    case (num)
      EXC_THREAD, EXC_NMI, EXC_HARD, EXC_MEM, EXC_BUS, EXC_USAGE: ok = 1'b1;
      EXC_SVC, EXC_PEND_SERVICE, EXC_TICK: ok = 1'b1;
      default:
        ok = (num >= EXC_IRQ_BASE) &&
             (num < EXC_IRQ_BASE + 9'(IRQ_COUNT)) && (num <= EXC_IRQ_LAST);
    endcase
    return ok;
  endfunction : exc_legal

  // Place the eight shared execution bits in word position
  function automatic logic [31:0] exec_place(input logic [7:0] st);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[EXEC_HI_MSB:EXEC_HI_LSB] = st[7:6];
    w[EXEC_LO_MSB:EXEC_LO_LSB] = st[5:0];
    w[COMPACT_BIT] = 1'b1;
    return w;
  endfunction : exec_place

  cond_block_tracker u_block
  (
    .clk(clk),
    .rst(rst),
    .block_start(block_start & ~xfer_q),
    .block_init(block_init),
    .instr_retire(block_retire),
    .clear(exc_enter | xfer_suspend),
    .block_state(blk_bits),
    .block_active(blk_active)
  );

  // Full word from all three parts
  always_comb
  begin
    full_word = exec_place(exec_q);
    full_word[NEG_BIT:SAT_BIT] = flags_q;
    full_word[EXC_NUM_MSB:0] = exc_q;
  end

  // Next flag values; hardware events win over a software write
  always_comb
  begin
    flags_d = flags_q;
    if (flags_we)
    begin
      flags_d[4:1] = {flag_n, flag_z, flag_c, flag_v};
    end
    if (sr_write && sr_sel[0])
    begin
      // Write only the flag bits; reserved and other parts untouched
      flags_d = sr_wdata[NEG_BIT:SAT_BIT];
      if (flags_we)
      begin
        flags_d[4:1] = {flag_n, flag_z, flag_c, flag_v};
      end
    end
    if (sat_event)
    begin
      flags_d[0] = 1'b1;
    end
  end

  // Flag register
  // Saturation bit stays set until software writes it to zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flags_q <= FLAGS_RST;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  // Next exception number; only entry or return moves it, never a write
  always_comb
  begin
    exc_d = exc_q;
    if (exc_enter)
    begin
      exc_d = exc_number;
    end
    else if (exc_return)
    begin
      exc_d = exc_ret_number;
    end
    // Legality follows the number that will be held next cycle
    legal_d = exc_legal(exc_d);
  end

  // Exception number register and its legality flag
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      exc_q <= EXC_NUM_RST;
      legal_q <= EXC_LEGAL_RST;
    end
    else
    begin
      exc_q <= exc_d;
      legal_q <= legal_d;
    end
  end

  // Next execution state; a suspend takes precedence over all else
  // A block state restored on return is dropped once the tracker is idle
  always_comb
  begin
    exec_d = exec_q;
    xfer_d = xfer_q;
    if (xfer_suspend)
    begin
      exec_d = {2'b00, xfer_next_reg, 2'b00};
      xfer_d = 1'b1;
    end
    else if (exc_return)
    begin
      exec_d = exc_ret_exec;
      xfer_d = (exc_ret_exec[7:6] == 2'b00) && (exc_ret_exec[1:0] == 2'b00) &&
               (exc_ret_exec[5:2] != 4'h0);
    end
    else if (xfer_q)
    begin
      if (xfer_resume_done)
      begin
        exec_d = EXEC_STATE_RST;
        xfer_d = 1'b0;
      end
    end
    // Tracker's next byte, so the state shows one cycle after its cause
    else if (blk_active)
    begin
      exec_d = blk_bits;
    end
    else
    begin
      exec_d = EXEC_STATE_RST;
    end
  end

  // Execution state register and the transfer-held marker
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      exec_q <= EXEC_STATE_RST;
      xfer_q <= XFER_HELD_RST;
    end
    else
    begin
      exec_q <= exec_d;
      xfer_q <= xfer_d;
    end
  end

  // Next read data; parts not selected read as zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (sr_read)
    begin
      if (sr_sel[0])
      begin
        rdata_d[NEG_BIT:SAT_BIT] = flags_q;
      end
      if (sr_sel[1])
      begin
        rdata_d[EXC_NUM_MSB:0] = exc_q;
      end
      // Execution part never reaches software, bit 24 included
      if (sr_sel[2])
      begin
        rdata_d = rdata_d & ~exec_place(8'hff);
      end
    end
  end

  // Read data register; a read answers one cycle later
  // Idle cycles return zero so stale data never lingers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= READ_DATA_RST;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // Capture the full word on entry; held until the next entry
  // Entry and capture share one edge, so the word is the pre-entry state
  always_comb
  begin
    stack_d = stack_q;
    if (exc_enter)
    begin
      stack_d = full_word;
    end
  end

  // Stacked copy register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stack_q <= STACK_WORD_RST;
    end
    else
    begin
      stack_q <= stack_d;
    end
  end

  // Outputs come straight from registers
  assign sr_rdata = rdata_q;
  assign stacked_word = stack_q;
  assign resume_reg = exec_q[5:2];
  assign resume_valid = xfer_q;
  assign cond_state = exec_q;
  assign exc_valid_num = legal_q;
endmodule : program_status_register

// ---- testbench/exc_entry_model.sv ----
`timescale 1ns/1ns
// Exception entry and return logic facing the status word
module exc_entry_model
(
  input wire logic enter_req, // Take an exception
  input wire logic return_req, // Leave the handler
  input wire logic [8:0] enter_num, // Exception to take
  input wire logic [31:0] stacked_word, // Word saved at entry
  output logic exc_enter, // Entry pulse
  output logic [8:0] exc_number, // Entry number
  output logic exc_return, // Return pulse
  output logic [8:0] exc_ret_number, // Restored number
  output logic [7:0] exc_ret_exec // Restored exec state
);
  // Entry passes straight through
  assign exc_enter = enter_req;
  assign exc_number = enter_num;
  // Return restores number and exec state from the stacked copy
  assign exc_return = return_req;
  assign exc_ret_number = stacked_word[8:0];
  assign exc_ret_exec = {stacked_word[26:25], stacked_word[15:10]};
endmodule : exc_entry_model

// ---- testbench/psr_assertions.sv ----
`timescale 1ns/1ns
// Port-level checks of the status word
module status_word_checker
  import status_word_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic flags_we, // Flag load
  input wire logic flag_n, // N in
  input wire logic flag_z, // Z in
  input wire logic flag_c, // C in
  input wire logic flag_v, // V in
  input wire logic sat_event, // Saturated
  input wire logic sr_read, // Read
  input wire logic sr_write, // Write
  input wire logic [2:0] sr_sel, // Parts
  input wire logic [31:0] sr_rdata, // Read data
  input wire logic exc_enter, // Entry
  input wire logic [8:0] exc_number, // Entry number
  input wire logic xfer_suspend, // Suspend
  input wire logic [3:0] xfer_next_reg, // Next reg
  input wire logic [3:0] resume_reg, // Resume reg
  input wire logic resume_valid, // State held
  input wire logic [7:0] cond_state, // Exec byte
  input wire logic [31:0] stacked_word, // Stacked
  input wire logic exc_valid_num // Legal number
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Flag or saturation event followed by an application read
  sequence s_flag_rd;
    flags_we ##1 (sr_read && sr_sel[0] && !flags_we && !sr_write);
  endsequence
  sequence s_sat_rd;
    sat_event ##1 (sr_read && sr_sel[0] && !sr_write);
  endsequence
  a_read_idle_zero: assert property (
    !sr_read |=> sr_rdata == 32'h0) else $error("idle read data not zero");
  a_exec_read_zero: assert property (
    sr_read && sr_sel == SEL_EXEC |=> sr_rdata == 32'h0) else $error("exec read not zero");
  a_reserved_read_zero: assert property (
    sr_read |=> sr_rdata[26:9] == 18'h0) else $error("reserved bits not zero");
  a_flags_read_back: assert property (
    s_flag_rd |=> sr_rdata[31:28] == {$past(flag_n, 2), $past(flag_z, 2),
    $past(flag_c, 2), $past(flag_v, 2)}) else $error("flags not loaded");
  a_sat_sticky_set: assert property (
    s_sat_rd |=> sr_rdata[27]) else $error("saturation flag not set");
  a_suspend_records_reg: assert property (
    xfer_suspend |=> resume_valid && resume_reg == $past(xfer_next_reg))
    else $error("next register not recorded");
  a_transfer_zero_bits: assert property (
    resume_valid |-> cond_state[7:6] == 2'h0 && cond_state[1:0] == 2'h0 &&
    cond_state[5:2] == resume_reg) else $error("transfer state bits wrong");
  a_stack_compact_bit: assert property (
    exc_enter |=> stacked_word[24] && stacked_word[23:16] == 8'h0 && !stacked_word[9])
    else $error("stacked word layout wrong");
  a_irq_number_legal: assert property (
    exc_enter && exc_number >= EXC_IRQ_BASE && exc_number <= EXC_IRQ_LAST
    |-> ##[1:2] exc_valid_num) else $error("irq number not legal");
endmodule : status_word_checker

bind program_status_register status_word_checker chk (.*);

// ---- testbench/test_program_status_register.sv ----
`timescale 1ns/1ns
// Self-checking bench for the status word
module test_program_status_register;
  import status_word_pkg::*;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
  logic clk, rst, flags_we, flag_n, flag_z, flag_c, flag_v, sat_event;
  logic sr_read, sr_write, exc_enter, exc_return, xfer_suspend, xfer_resume_done;
  logic block_start, block_retire, enter_req, return_req, resume_valid, exc_valid_num;
  logic [2:0] sr_sel;
  logic [31:0] sr_wdata, sr_rdata, stacked_word;
  logic [8:0] exc_number, exc_ret_number, enter_num;
  logic [7:0] exc_ret_exec, block_init, cond_state;
  logic [3:0] xfer_next_reg, resume_reg;
  int n_mismatch = 0;
  int n_checks = 0;
  program_status_register dut (.*);
  exc_entry_model model (.*);
  // Special-register read, checked one cycle later, then one idle cycle
  task automatic rd(input logic [2:0] sel, input logic [31:0] exp);
    sr_read = 1'b1;
    sr_sel = sel;
    @(negedge clk);
    sr_read = 1'b0;
    `CHK(sr_rdata, exp)
    @(negedge clk);
  endtask : rd
  task automatic wr(input logic [2:0] sel, input logic [31:0] data);
    sr_write = 1'b1;
    sr_sel = sel;
    sr_wdata = data;
    @(negedge clk);
    sr_write = 1'b0;
  endtask : wr
  task automatic t_flags();
    for (int i = 0; i < 16; i++)
    begin
      flags_we = 1'b1;
      {flag_n, flag_z, flag_c, flag_v} = 4'(i);
      @(negedge clk);
      flags_we = 1'b0;
      rd(SEL_APP, {4'(i), 28'h0});
    end
    {flag_n, flag_z, flag_c, flag_v} = 4'h0;
    rd(SEL_APP, 32'hf000_0000);
    wr(SEL_APP, 32'h5000_ffff);
    rd(SEL_APP, 32'h5000_0000);
    wr(SEL_INT | SEL_EXEC, 32'h0700_01ff);
    rd(SEL_INT | SEL_EXEC, 32'h0);
    $display("flag test done");
  endtask : t_flags
  task automatic t_sat();
    sat_event = 1'b1;
    @(negedge clk);
    sat_event = 1'b0;
    rd(SEL_APP, 32'h5800_0000);
    flags_we = 1'b1;
    @(negedge clk);
    flags_we = 1'b0;
    rd(SEL_APP, 32'h0800_0000);
    sat_event = 1'b1;
    wr(SEL_APP, 32'h0);
    sat_event = 1'b0;
    rd(SEL_APP, 32'h0800_0000);
    wr(SEL_APP, 32'h0);
    rd(SEL_APP, 32'h0);
    $display("saturation test done");
  endtask : t_sat
  task automatic t_exc();
    logic [8:0] nums [17] = '{9'h1, 9'h2, 9'h3, 9'h4, 9'h5, 9'h6, 9'h7, 9'ha, 9'hb,
      9'hc, 9'hd, 9'he, 9'hf, 9'h53, 9'h54, 9'h1ff, 9'h10};
    logic ok;
    for (int i = 0; i < 17; i++)
    begin
      enter_req = 1'b1;
      enter_num = nums[i];
      @(negedge clk);
      enter_req = 1'b0;
      @(negedge clk);
      ok = nums[i] inside {[9'h2:9'h6], 9'hb, [9'he:9'h53]};
      `CHK(exc_valid_num, ok)
      rd(SEL_APP | SEL_INT, {23'h0, nums[i]});
    end
    $display("exception number test done");
  endtask : t_exc
  task automatic t_xfer();
    xfer_suspend = 1'b1;
    xfer_next_reg = 4'h5;
    @(negedge clk);
    xfer_suspend = 1'b0;
    `CHK({resume_valid, resume_reg, cond_state}, {1'b1, 4'h5, 8'h14})
    block_start = 1'b1;
    block_init = 8'hff;
    @(negedge clk);
    block_start = 1'b0;
    `CHK(cond_state, 8'h14)
    enter_req = 1'b1;
    enter_num = EXC_IRQ_LAST;
    @(negedge clk);
    enter_req = 1'b0;
    `CHK(stacked_word, 32'h0100_5010)
    return_req = 1'b1;
    @(negedge clk);
    return_req = 1'b0;
    `CHK({resume_reg, cond_state}, {4'h5, 8'h14})
    rd(SEL_INT, 32'h10);
    xfer_resume_done = 1'b1;
    @(negedge clk);
    xfer_resume_done = 1'b0;
    `CHK(resume_valid, 1'b0)
    $display("transfer test done");
  endtask : t_xfer
  task automatic t_block();
    block_start = 1'b1;
    block_init = 8'h18;
    @(negedge clk);
    block_start = 1'b0;
    `CHK(cond_state, 8'h18)
    block_retire = 1'b1;
    repeat (4) @(negedge clk);
    block_retire = 1'b0;
    `CHK(cond_state, 8'h00)
    block_start = 1'b1;
    block_init = 8'h21;
    @(negedge clk);
    block_start = 1'b0;
    block_retire = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(cond_state, 8'h28)
    @(negedge clk);
    block_retire = 1'b0;
    `CHK(cond_state, 8'h00)
    $display("block test done");
  endtask : t_block
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog
  initial
  begin
    #100000;
    n_mismatch++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    rst = 1'b1;
    {flags_we, flag_n, flag_z, flag_c, flag_v, sat_event, sr_read, sr_write} = 8'h0;
    {xfer_suspend, xfer_resume_done, block_start, block_retire} = 4'h0;
    {enter_req, return_req, enter_num, sr_sel, sr_wdata} = '0;
    {block_init, xfer_next_reg} = 12'h0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    `CHK(stacked_word, 32'h0100_0000)
    `CHK(exc_valid_num, 1'b1)
    rd(3'h7, 32'h0);
    t_flags();
    t_sat();
    t_exc();
    t_xfer();
    t_block();
    end_sim();
  end
endmodule : test_program_status_register
